// *** delay_timer.sv ***
`timescale 1ns/1ps
module delay_timer
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control
  input wire logic enable,
  input wire logic time_tick,
  input wire logic timer_req,
  input wire logic [15:0] on_delay,
  input wire logic [15:0] off_delay,
  // result
  output logic timer_out
);
  import fb_pkg::*;

  tmr_state_t state_reg;
  tmr_state_t state_next;
  logic [15:0] elapsed_reg;
  logic [15:0] elapsed_next;

  // ***************************************************
  // on and off qualification
  // ***************************************************
  always_comb
  begin
    state_next = state_reg;
    elapsed_next = elapsed_reg;
    if (!enable)
    begin
      state_next = TMR_IDLE;
      elapsed_next = 16'h0000;
    end
    else
    begin
      case (state_reg)
        TMR_IDLE:
        begin
          if (!timer_req)
            elapsed_next = 16'h0000;
          else if (elapsed_reg >= on_delay)
          begin
            state_next = TMR_ACTIVE;
            elapsed_next = 16'h0000;
          end
          else if (time_tick)
            elapsed_next = elapsed_reg + 16'h0001;
        end
        TMR_ACTIVE:
        begin
          if (timer_req)
            elapsed_next = 16'h0000;
          else if (elapsed_reg >= off_delay)
          begin
            state_next = TMR_IDLE;
            elapsed_next = 16'h0000;
          end
          else if (time_tick)
            elapsed_next = elapsed_reg + 16'h0001;
        end
        default:
        begin
          state_next = TMR_IDLE;
          elapsed_next = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_reg <= TMR_IDLE;
      elapsed_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      elapsed_reg <= elapsed_next;
    end
  end

  assign timer_out = (state_reg == TMR_ACTIVE);

endmodule

// *** fb_params_checker_assertions.sv ***
`timescale 1ns/1ps
module fb_params_checker
  import fb_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [fb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  // function inputs
  input wire logic in1_eval,
  input wire logic in2_eval,
  input wire logic timer_req,
  // results
  input wire logic [fb_pkg::DATA_W-1:0] func_out1,
  input wire logic timer_out,
  input wire logic [31:0] count_value,
  input wire logic [31:0] limit_primary,
  input wire logic [31:0] limit_alternate,
  input wire logic per_unit_mode,
  input wire logic [fb_pkg::DATA_W-1:0] in4_value
);
  logic [15:0] sh_reg [0:4];
  logic [15:0] sh_next [0:4];
  logic [4:0] sel;
  logic [31:0] lim_a;
  logic [31:0] lim_b;
  assign sel = sh_reg[4][4:0];
  assign lim_a = {sh_reg[0], sh_reg[1]};
  assign lim_b = {sh_reg[2], sh_reg[3]};
  // ***************************************************
  // shadow of the written parameters
  // ***************************************************
  always_comb
  begin
    sh_next = sh_reg;
    // selector writes out of range are ignored by the block as well
    if (reg_wr && reg_addr < 4'h5
        && (reg_addr != IDX_FUNC_SEL || reg_wdata <= 16'(SEL_MAX)))
      sh_next[reg_addr[2:0]] = reg_wdata;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sh_reg <= '{default: 16'h0000};
    else
      sh_reg <= sh_next;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_timer_rise: assert property (
    $rose(timer_out) |-> $past(timer_req)) else $error("timer rose early");
  a_timer_fall: assert property (
    $fell(timer_out) && (sel == SEL_TIMER || sel == SEL_STATE)
      |-> !$past(timer_req)) else $error("timer fell early");
  a_count_cause: assert property (
    $changed(count_value) |-> $past(srst)
      || ($past(in1_eval) && !$past(in1_eval, 2))
      || ($past(in2_eval) && !$past(in2_eval, 2))
      || ($past(sh_reg[2]) == 16'h0000
        && $past(count_value[31:16]) != 16'h0000))
    else $error("count moved without edge");
  a_count_narrow: assert property (
    (sel == SEL_COUNTER && sh_reg[2] == 16'h0000) [*2]
      |-> count_value[31:16] == 16'h0000) else $error("narrow count wide");
  a_out_timer: assert property (
    sel == SEL_TIMER && timer_out |=> func_out1 == $past(sh_reg[2]))
    else $error("timer output value wrong");
  a_out_state: assert property (
    sel == SEL_STATE && in1_eval && !in2_eval && timer_out
      |=> func_out1 == $past(sh_reg[2])) else $error("state output wrong");
  a_per_unit_sel: assert property (
    sel == SEL_MULDIV |=> per_unit_mode == ($past(sh_reg[0]) != 16'h0000))
    else $error("per unit flag wrong");
  a_scale_limits: assert property (
    sel == SEL_SCALE && sh_reg[0] != SIGNED_LOW_ILLEGAL
      && sh_reg[2] != SIGNED_LOW_ILLEGAL
      |=> limit_primary == $past(lim_a) && limit_alternate == $past(lim_b))
    else $error("scale limits wrong");
  a_reset_clear: assert property (
    $fell(srst) |-> in4_value == 16'h0000 && count_value == 32'h0
      && timer_out == 1'b0 && func_out1 == 16'h0000)
    else $error("outputs not cleared by reset");
endmodule

bind fb_params_top fb_params_checker i_fb_params_checker (
  .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .in1_eval(in1_eval),
  .in2_eval(in2_eval), .timer_req(timer_req), .func_out1(func_out1),
  .timer_out(timer_out), .count_value(count_value),
  .limit_primary(limit_primary), .limit_alternate(limit_alternate),
  .per_unit_mode(per_unit_mode), .in4_value(in4_value));

// *** fb_params_top.sv ***
`timescale 1ns/1ps
module fb_params_top
#(
  parameter int unsigned TICK_CYCLES = fb_pkg::TIME_UNIT_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire logic [fb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fb_pkg::DATA_W-1:0] reg_rdata,
  // evaluated function inputs
  input wire logic in1_eval,
  input wire logic in2_eval,
  input wire logic timer_req,
  // results
  output logic [fb_pkg::DATA_W-1:0] func_out1,
  output logic timer_out,
  output logic [31:0] count_value,
  output logic [31:0] limit_primary,
  output logic [31:0] limit_alternate,
  output logic per_unit_mode,
  output logic [fb_pkg::DATA_W-1:0] in4_value
);
  import fb_pkg::*;
  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic sel_in(input logic [4:0] sel, lo, hi);
    sel_in = (sel >= lo) && (sel <= hi);
  endfunction
  function automatic logic [15:0] clamp_signed(input logic [15:0] v);
    clamp_signed = (v == SIGNED_LOW_ILLEGAL) ? SIGNED_MIN : v;
  endfunction
  // ***************************************************
  // parameter registers
  // ***************************************************
  logic [15:0] in_four_reg;
  logic [15:0] in_four_next;
  logic [15:0] in_five_reg;
  logic [15:0] in_five_next;
  logic [15:0] in_six_reg;
  logic [15:0] in_six_next;
  logic [15:0] in_seven_reg;
  logic [15:0] in_seven_next;
  logic [4:0] sel_reg;
  logic [4:0] sel_next;
  always_comb
  begin
    in_four_next = in_four_reg;
    in_five_next = in_five_reg;
    in_six_next = in_six_reg;
    in_seven_next = in_seven_reg;
    sel_next = sel_reg;
    if (reg_wr)
    begin
      if (reg_addr == IDX_IN_FOUR)
        in_four_next = reg_wdata;
      else if (reg_addr == IDX_IN_FIVE)
        in_five_next = reg_wdata;
      else if (reg_addr == IDX_IN_SIX)
        in_six_next = reg_wdata;
      else if (reg_addr == IDX_IN_SEVEN)
        in_seven_next = reg_wdata;
      else if (reg_addr == IDX_FUNC_SEL)
      begin
        // out of range selector values are ignored
        if (reg_wdata[4:0] <= SEL_MAX && reg_wdata[15:5] == 11'h000)
          sel_next = reg_wdata[4:0];
      end
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      in_four_reg <= PARAM_RST;
      in_five_reg <= PARAM_RST;
      in_six_reg <= PARAM_RST;
      in_seven_reg <= PARAM_RST;
      sel_reg <= SEL_RST;
    end
    else
    begin
      in_four_reg <= in_four_next;
      in_five_reg <= in_five_next;
      in_six_reg <= in_six_next;
      in_seven_reg <= in_seven_next;
      sel_reg <= sel_next;
    end
  end
  // ***************************************************
  // mode decode and value interpretation
  // ***************************************************
  logic mode_time;
  logic mode_timer;
  logic mode_state;
  logic mode_counter;
  logic mode_muldiv;
  logic mode_scale;
  logic [15:0] four_eff;
  logic [15:0] five_eff;
  logic [15:0] six_eff;
  always_comb
  begin
    mode_time = sel_in(sel_reg, SEL_TIMER, SEL_TIME_LAST);
    mode_timer = (sel_reg == SEL_TIMER);
    mode_state = (sel_reg == SEL_STATE);
    mode_counter = (sel_reg == SEL_COUNTER);
    mode_muldiv = (sel_reg == SEL_MULDIV);
    mode_scale = (sel_reg == SEL_SCALE);
    // sampled from the registers on every pass, four and six through clamp_signed in scale mode
    four_eff = in_four_reg;
    if (sel_reg == SEL_SCALE)
      four_eff = clamp_signed(in_four_reg);
    five_eff = in_five_reg;
    six_eff = in_six_reg;
    if (sel_reg == SEL_SCALE)
      six_eff = clamp_signed(in_six_reg);
  end
  // ***************************************************
  // time base: one tick per hundredth of a minute
  // ***************************************************
  logic [31:0] tick_cnt_reg;
  logic [31:0] tick_cnt_next;
  logic tick_reg;
  logic tick_next;
  always_comb
  begin
    tick_cnt_next = tick_cnt_reg + 32'h0000_0001;
    tick_next = 1'b0;
    if (!mode_time)
      tick_cnt_next = 32'h0000_0000;
    else if (tick_cnt_reg >= TICK_CYCLES - 1)
    begin
      tick_cnt_next = 32'h0000_0000;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end
  // ***************************************************
  // delay timer
  // ***************************************************
  logic timer_q;
  delay_timer u_timer
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .enable(mode_timer || mode_state),
    .time_tick(tick_reg),
    .timer_req(timer_req),
    .on_delay(five_eff),
    .off_delay(four_eff),
    .timer_out(timer_q)
  );
  // ***************************************************
  // up/down counter
  // ***************************************************
  logic in1_prev_reg;
  logic in2_prev_reg;
  logic up_pulse;
  logic down_pulse;
  always_comb
  begin
    up_pulse = mode_counter && in1_eval && !in1_prev_reg;
    down_pulse = mode_counter && in2_eval && !in2_prev_reg;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      in1_prev_reg <= 1'b0;
      in2_prev_reg <= 1'b0;
    end
    else
    begin
      in1_prev_reg <= in1_eval;
      in2_prev_reg <= in2_eval;
    end
  end
  updown_counter u_counter
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .up_pulse(up_pulse),
    .down_pulse(down_pulse),
    .up_step(four_eff),
    .down_step(five_eff),
    .wide(in_six_reg != 16'h0000),
    .count_value(count_value)
  );
  // ***************************************************
  // result registers
  // ***************************************************
  logic [15:0] out1_reg;
  logic [15:0] out1_next;
  logic [31:0] lim_a_reg;
  logic [31:0] lim_a_next;
  logic [31:0] lim_b_reg;
  logic [31:0] lim_b_next;
  logic per_unit_reg;
  logic per_unit_next;
  logic [15:0] four_out_reg;
  always_comb
  begin
    out1_next = out1_reg;
    lim_a_next = lim_a_reg;
    lim_b_next = lim_b_reg;
    per_unit_next = 1'b0;
    if (mode_timer)
      out1_next = timer_q ? six_eff : in_seven_reg;
    else if (mode_state)
    begin
      if (!in2_eval && in1_eval && timer_q)
        out1_next = six_eff;
      else if (in2_eval && !(in1_eval && timer_q))
        out1_next = in_seven_reg;
    end
    else if (mode_counter)
      out1_next = count_value[15:0];
    else if (mode_muldiv)
      per_unit_next = (four_eff != 16'h0000);
    else if (mode_scale)
    begin
      lim_a_next = {four_eff, five_eff};
      lim_b_next = {six_eff, in_seven_reg};
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      out1_reg <= 16'h0000;
      lim_a_reg <= 32'h0000_0000;
      lim_b_reg <= 32'h0000_0000;
      per_unit_reg <= 1'b0;
      four_out_reg <= 16'h0000;
    end
    else
    begin
      out1_reg <= out1_next;
      lim_a_reg <= lim_a_next;
      lim_b_reg <= lim_b_next;
      per_unit_reg <= per_unit_next;
      four_out_reg <= four_eff;
    end
  end
  assign func_out1 = out1_reg;
  assign timer_out = timer_q;
  assign limit_primary = lim_a_reg;
  assign limit_alternate = lim_b_reg;
  assign per_unit_mode = per_unit_reg;
  assign in4_value = four_out_reg;

  // ***************************************************
  // register read
  // ***************************************************
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb
  begin
    rdata_next = 16'h0000;
    if (reg_rd)
    begin
      if (reg_addr == IDX_IN_FOUR)
        rdata_next = in_four_reg;
      else if (reg_addr == IDX_IN_FIVE)
        rdata_next = in_five_reg;
      else if (reg_addr == IDX_IN_SIX)
        rdata_next = in_six_reg;
      else if (reg_addr == IDX_IN_SEVEN)
        rdata_next = in_seven_reg;
      else if (reg_addr == IDX_FUNC_SEL)
        rdata_next = {11'h000, sel_reg};
      else if (reg_addr == IDX_STATUS)
      begin
        rdata_next[STAT_TIMER_BIT] = timer_q;
        rdata_next[STAT_PER_UNIT_BIT] = per_unit_reg;
        rdata_next[STAT_WIDE_BIT] = (in_six_reg != 16'h0000);
      end
      else if (reg_addr == IDX_COUNT_LO)
        rdata_next = count_value[15:0];
      else if (reg_addr == IDX_COUNT_HI)
        rdata_next = count_value[31:16];
      else if (reg_addr == IDX_OUT_ONE)
        rdata_next = out1_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rdata_next;
  end

  assign reg_rdata = rdata_reg;

endmodule

// *** fb_pkg.sv ***
package fb_pkg;

  // ***************************************************
  // bus and data widths
  // ***************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ***************************************************
  // register indices
  // ***************************************************
  localparam logic [3:0] IDX_IN_FOUR = 4'h0;
  localparam logic [3:0] IDX_IN_FIVE = 4'h1;
  localparam logic [3:0] IDX_IN_SIX = 4'h2;
  localparam logic [3:0] IDX_IN_SEVEN = 4'h3;
  localparam logic [3:0] IDX_FUNC_SEL = 4'h4;
  localparam logic [3:0] IDX_STATUS = 4'h5;
  localparam logic [3:0] IDX_COUNT_LO = 4'h6;
  localparam logic [3:0] IDX_COUNT_HI = 4'h7;
  localparam logic [3:0] IDX_OUT_ONE = 4'h8;

  // ***************************************************
  // field positions and reset values
  // ***************************************************
  localparam int STAT_TIMER_BIT = 0;
  localparam int STAT_PER_UNIT_BIT = 1;
  localparam int STAT_WIDE_BIT = 2;
  localparam int SEL_W = 5;
  localparam logic [15:0] PARAM_RST = 16'h0000;
  localparam logic [4:0] SEL_RST = 5'h00;

  // ***************************************************
  // function selector values
  // ***************************************************
  localparam logic [4:0] SEL_TIMER = 5'h00;
  localparam logic [4:0] SEL_STATE = 5'h01;
  localparam logic [4:0] SEL_TIME_LAST = 5'h08;
  localparam logic [4:0] SEL_MULDIV = 5'h09;
  localparam logic [4:0] SEL_UNS_LAST = 5'h0C;
  localparam logic [4:0] SEL_COUNTER = 5'h0C;
  localparam logic [4:0] SEL_SCALE = 5'h0D;
  localparam logic [4:0] SEL_MAX = 5'h1B;

  // ***************************************************
  // signed range limits
  // ***************************************************
  localparam logic [15:0] SIGNED_MIN = 16'h8001;
  localparam logic [15:0] SIGNED_LOW_ILLEGAL = 16'h8000;

  // ***************************************************
  // timing: one time unit is a hundredth of a minute
  // ***************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TIME_UNIT_MS = 600;
  localparam int unsigned TIME_UNIT_CYCLES =
    TIME_UNIT_MS * (CLK_HZ / 1000);

  typedef enum logic {TMR_IDLE, TMR_ACTIVE} tmr_state_t;

endpackage

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import fb_pkg::*;
  localparam int TICK = 4;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic in1_eval = 1'b0;
  logic in2_eval = 1'b0;
  logic timer_req = 1'b0;
  logic [15:0] reg_rdata, func_out1, in4_value;
  logic timer_out, per_unit_mode;
  logic [31:0] count_value, limit_primary, limit_alternate;
  int fails = 0;
  int tests_run = 0;

  fb_params_top #(.TICK_CYCLES(TICK)) i_fb_params_top (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in1_eval(in1_eval), .in2_eval(in2_eval),
    .timer_req(timer_req), .func_out1(func_out1), .timer_out(timer_out),
    .count_value(count_value), .limit_primary(limit_primary),
    .limit_alternate(limit_alternate), .per_unit_mode(per_unit_mode),
    .in4_value(in4_value));

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ***************************************************
  // access and check tasks
  // ***************************************************
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("read data", 32'(reg_rdata), 32'(exp));
  endtask
  task automatic wait_timer(input logic lvl);
    for (int i = 0; i < 40 && timer_out !== lvl; i++)
      cyc(1);
    chk("timer level", 32'(timer_out), 32'(lvl));
  endtask
  task automatic pulse(input logic up, input logic dn);
    @(posedge clk_sys);
    in1_eval <= up;
    in2_eval <= dn;
    @(posedge clk_sys);
    in1_eval <= 1'b0;
    in2_eval <= 1'b0;
    cyc(2);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #50us;
    fails++;
    end_of_test();
  end

  // ***************************************************
  // test sequence
  // ***************************************************
  initial
  begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++)
      rd(4'(i), 16'h0000);
    wr(4'hF, 16'h1234);
    rd(4'hF, 16'h0000);
    wr(IDX_IN_SIX, 16'hA5A5);
    wr(IDX_IN_SEVEN, 16'h5A5A);
    wr(IDX_IN_FOUR, 16'h0002);
    rd(IDX_IN_SIX, 16'hA5A5);
    @(posedge clk_sys);
    timer_req <= 1'b1;
    cyc(2);
    chk("timer zero delay", 32'(timer_out), 32'h1);
    cyc(1);
    chk("out one timer true", 32'(func_out1), 32'hA5A5);
    @(posedge clk_sys);
    timer_req <= 1'b0;
    cyc(TICK);
    chk("off delay hold", 32'(timer_out), 32'h1);
    wait_timer(1'b0);
    cyc(2);
    chk("out one timer false", 32'(func_out1), 32'h5A5A);
    wr(IDX_IN_FIVE, 16'h0002);
    @(posedge clk_sys);
    timer_req <= 1'b1;
    cyc(TICK);
    chk("on delay hold", 32'(timer_out), 32'h0);
    wait_timer(1'b1);
    wr(IDX_FUNC_SEL, 16'(SEL_STATE));
    @(posedge clk_sys);
    in2_eval <= 1'b1;
    cyc(2);
    chk("state in2 output", 32'(func_out1), 32'h5A5A);
    @(posedge clk_sys);
    in2_eval <= 1'b0;
    in1_eval <= 1'b1;
    wait_timer(1'b1);
    cyc(2);
    chk("state output", 32'(func_out1), 32'hA5A5);
    @(posedge clk_sys);
    in1_eval <= 1'b0;
    timer_req <= 1'b0;
    wait_timer(1'b0);
    wr(IDX_IN_FOUR, 16'h0005);
    wr(IDX_IN_FIVE, 16'h0003);
    wr(IDX_IN_SIX, 16'h0000);
    wr(IDX_FUNC_SEL, 16'(SEL_COUNTER));
    pulse(1'b1, 1'b0);
    chk("count up", count_value, 32'h5);
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b1);
    chk("count word wrap", count_value, 32'hFFFF);
    pulse(1'b1, 1'b1);
    chk("count both", count_value, 32'h1);
    wr(IDX_IN_SIX, 16'h0001);
    pulse(1'b0, 1'b1);
    chk("count double", count_value, 32'hFFFFFFFE);
    rd(IDX_COUNT_LO, 16'hFFFE);
    rd(IDX_COUNT_HI, 16'hFFFF);
    rd(IDX_STATUS, 16'h0004);
    rd(IDX_OUT_ONE, 16'hFFFE);
    wr(IDX_FUNC_SEL, 16'(SEL_MULDIV));
    wr(IDX_IN_FOUR, 16'h0000);
    cyc(2);
    chk("math mode", 32'(per_unit_mode), 32'h0);
    wr(IDX_IN_FOUR, 16'hFFFF);
    cyc(2);
    chk("per unit mode", 32'(per_unit_mode), 32'h1);
    chk("unsigned four", 32'(in4_value), 32'hFFFF);
    wr(IDX_FUNC_SEL, 16'(SEL_SCALE));
    wr(IDX_IN_FOUR, 16'h1234);
    wr(IDX_IN_FIVE, 16'h5678);
    wr(IDX_IN_SIX, 16'h9ABC);
    wr(IDX_IN_SEVEN, 16'hDEF0);
    cyc(2);
    chk("primary limit", limit_primary, 32'h12345678);
    chk("alternate limit", limit_alternate, 32'h9ABCDEF0);
    wr(IDX_IN_FOUR, 16'h8000);
    cyc(2);
    chk("signed clamp", 32'(in4_value), 32'(SIGNED_MIN));
    @(posedge clk_sys);
    srst <= 1'b1;
    cyc(3);
    @(posedge clk_sys);
    srst <= 1'b0;
    rd(IDX_IN_FOUR, 16'h0000);
    chk("count after reset", count_value, 32'h0);
    end_of_test();
  end
endmodule

// *** updown_counter.sv ***
`timescale 1ns/1ps
module updown_counter
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // steps
  input wire logic up_pulse,
  input wire logic down_pulse,
  input wire logic [15:0] up_step,
  input wire logic [15:0] down_step,
  input wire logic wide,
  // result
  output logic [31:0] count_value
);

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] sum;

  // ***************************************************
  // accumulate
  // ***************************************************
  always_comb
  begin
    sum = count_reg;
    if (up_pulse)
      sum = sum + {16'h0000, up_step};
    if (down_pulse)
      sum = sum - {16'h0000, down_step};
    count_next = wide ? sum : {16'h0000, sum[15:0]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      count_reg <= 32'h0000_0000;
    else
      count_reg <= count_next;
  end

  assign count_value = count_reg;

endmodule
